// ===== servo_pkg.sv
// package: constants and carrier types for the servo start and torque limit logic
package servo_pkg;
   // timing at 100 MHz
   localparam int unsigned CLK_HZ          = 100_000_000;
   localparam int unsigned CTRL_CYCLE_US   = 1000;
   localparam int unsigned CTRL_CYCLE_CLKS = (CLK_HZ / 1_000_000) * CTRL_CYCLE_US;
   localparam int unsigned START_LAT_MS    = 3;
   localparam int unsigned START_LAT_CLKS  = (CLK_HZ / 1000) * START_LAT_MS;
   localparam int unsigned START_HOLD_MS   = 6;
   localparam int unsigned START_HOLD_CLKS = (CLK_HZ / 1000) * START_HOLD_MS;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_INPOS  = 8'h08;
   localparam logic [7:0] OFS_ROUGH  = 8'h0C;
   localparam logic [7:0] OFS_FWD    = 8'h10;
   localparam logic [7:0] OFS_REV    = 8'h14;
   localparam logic [7:0] OFS_LIM2   = 8'h18;
   localparam logic [7:0] OFS_IRQST  = 8'h1C;
   localparam logic [7:0] OFS_IRQMSK = 8'h20;
   localparam logic [7:0] OFS_FORCE  = 8'h24;
   // control field positions
   localparam int unsigned CTRL_INDEXER = 0;
   localparam int unsigned CTRL_TEST    = 1;
   // reset values
   localparam logic [15:0] RST_INPOS = 16'h0064;
   localparam logic [15:0] RST_ROUGH = 16'h0000;
   localparam logic [15:0] RST_LIMIT = 16'h03E8;
   // interrupt bits: start accepted, move done, limiting
   localparam int unsigned IRQ_W = 3;
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_DELAY = 2'b01,
      ST_MOVE  = 2'b10
   } mot_state_t;
   // host remote inputs
   typedef struct packed {
      logic start_cmd_bit;
      logic servo_on_bit;
      logic torque_limit_select_bit;
      logic forced_stop_in;
   } host_in_t;
   // status outputs
   typedef struct packed {
      logic move_done_out;
      logic rough_match_out;
      logic in_position_out;
      logic torque_limiting_bit;
   } stat_out_t;
endpackage : servo_pkg

// ===== servo_start_and_torque_limit_logic.sv
// servo start sequencing, positioning status and torque limit selection
// Notes on behaviour
// - start ignored while main power circuit is not established
// - positioning begins only on start bit off-to-on transition
// - motion begins at most 3 ms after the start edge
// - start edges during a positioning operation are disregarded
// - on servo-on return after a stop during a start or positioning operation, done, rough and in-position assert
// - move done only in servo-on, timed by in-position range
// - rough match only in servo-on, timed by rough range, zero special
// - in-position compares feedback remaining pulses with in-position range
// - torque clamped to forward or reverse limit during operation
// - select 0: forward for ccw drive/cw regen, reverse otherwise
// - select 1: limit 2 both ways when lower, else fwd/rev kept
// - indexer mode enables limit 2 automatically while moving
// - limiting-torque output high when torque reaches active limit
// - forced output test mode drives each status output pin directly
// - servo-off shuts power stage and ends operation
//
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module servo_start_and_torque_limit_logic
   import servo_pkg::*;
#(
   parameter int unsigned CYCLE_CLKS = CTRL_CYCLE_CLKS,  // control cycle length
   parameter int unsigned POS_W      = 16                 // position width
) (
   input  wire logic              clk,            // clock 100 MHz
   input  wire logic              reset,          // sync reset, active high
   input  wire host_in_t          host_in,        // remote host bits, async
   input  wire logic              main_power_ok,  // main circuit established, async
   input  wire logic              alarm_in,       // alarm active
   input  wire logic [POS_W-1:0]  cmd_remain,     // command distance still to issue
   input  wire logic [POS_W-1:0]  droop,          // feedback pulses behind command
   input  wire logic              cmd_done,       // position command generation finished
   input  wire logic [15:0]       torque_req,     // requested torque magnitude
   input  wire logic              torque_ccw,     // torque direction ccw
   input  wire logic              regen,          // regenerating
   output logic [15:0]            torque_out,     // clamped torque
   output logic [15:0]            active_limit,   // selected limit
   output logic                   motion_start,   // one cycle pulse motion begins
   output logic                   power_on,       // power stage enabled
   output logic                   ready_out,      // ready
   output stat_out_t              stat_out,       // status pins
   output logic                   irq,            // interrupt level
   input  wire logic [7:0]        s_axi_awaddr,   // axi write address
   input  wire logic              s_axi_awvalid,  // aw valid
   output logic                   s_axi_awready,  // aw ready
   input  wire logic [31:0]       s_axi_wdata,    // write data
   input  wire logic [3:0]        s_axi_wstrb,    // write strobes
   input  wire logic              s_axi_wvalid,   // w valid
   output logic                   s_axi_wready,   // w ready
   output logic [1:0]             s_axi_bresp,    // write response
   output logic                   s_axi_bvalid,   // b valid
   input  wire logic              s_axi_bready,   // b ready
   input  wire logic [7:0]        s_axi_araddr,   // read address
   input  wire logic              s_axi_arvalid,  // ar valid
   output logic                   s_axi_arready,  // ar ready
   output logic [31:0]            s_axi_rdata,    // read data
   output logic [1:0]             s_axi_rresp,    // read response
   output logic                   s_axi_rvalid,   // r valid
   input  wire logic              s_axi_rready    // r ready
);
   // synchronisers for the async inputs
   logic [4:0] sync1_q, sync2_q;
   always_ff @(posedge clk) begin
      sync1_q <= {host_in, main_power_ok};
      sync2_q <= sync1_q;
   end
   wire logic start_s = sync2_q[4];
   wire logic servo_s = sync2_q[3];
   wire logic sel_s   = sync2_q[2];
   wire logic emg_s   = sync2_q[1];
   wire logic mpow_s  = sync2_q[0];

   // registers
   logic [1:0]        ctrl_q;
   logic [15:0]       inpos_q, rough_q, fwd_q, rev_q, lim2_q;
   logic [IRQ_W-1:0]  irqst_q, irqmsk_q;
   logic [3:0]        force_q;

   // control cycle tick
   logic [31:0] tick_cnt_q;
   wire logic   tick = (tick_cnt_q == CYCLE_CLKS - 1);
   always_ff @(posedge clk) begin
      if (reset || tick) tick_cnt_q <= '0;
      else               tick_cnt_q <= tick_cnt_q + 32'd1;
   end

   wire logic run_ok = servo_s && emg_s && !alarm_in && mpow_s;
   assign power_on  = run_ok;
   assign ready_out = run_ok;

   logic start_prev_q;
   always_ff @(posedge clk) begin
      if (reset)     start_prev_q <= 1'b1;
      else if (tick) start_prev_q <= start_s;
   end
   wire logic start_edge = tick && start_s && !start_prev_q && mpow_s && run_ok;

   // start sequencer
   mot_state_t st_q;
   logic [31:0] lat_q;
   logic        was_stopped_q;
   always_ff @(posedge clk) begin
      if (reset) begin
         st_q  <= ST_IDLE;
         lat_q <= '0;
      end else if (!run_ok) begin
         st_q <= ST_IDLE;
      end else begin
         case (st_q)
            ST_IDLE: if (start_edge) begin
               st_q  <= ST_DELAY;
               lat_q <= '0;
            end
            ST_DELAY: begin
               lat_q <= lat_q + 32'd1;
               if (lat_q == 32'd1) st_q <= ST_MOVE;
            end
            ST_MOVE: if (cmd_done && droop <= inpos_q[POS_W-1:0]) st_q <= ST_IDLE;
            default: st_q <= ST_IDLE;
         endcase
      end
   end
   assign motion_start = (st_q == ST_DELAY) && (lat_q == 32'd1) && run_ok;

   always_ff @(posedge clk) begin
      if (reset)                          was_stopped_q <= 1'b0;
      else if (!run_ok && st_q != ST_IDLE) was_stopped_q <= 1'b1;
      else if (run_ok)                    was_stopped_q <= 1'b0;
   end
   wire logic resumed = run_ok && was_stopped_q;

   wire logic inpos_c = droop <= inpos_q[POS_W-1:0];
   // rough match, zero range means command finished
   wire logic rough_c = (rough_q == 16'h0000) ? cmd_done : (cmd_remain <= rough_q[POS_W-1:0]);
   // move done after command and in-position
   wire logic done_c  = cmd_done && inpos_c && st_q != ST_DELAY;
   logic done_q, rough_q2, inp_q;
   always_ff @(posedge clk) begin
      if (reset || !run_ok) begin
         done_q   <= 1'b0;
         rough_q2 <= 1'b0;
         inp_q    <= 1'b0;
      end else begin
         done_q   <= done_c || resumed;
         rough_q2 <= rough_c || resumed;
         inp_q    <= inpos_c || resumed;
      end
   end

   wire logic        fwd_dir = torque_ccw ^ regen;
   wire logic [15:0] dir_lim = fwd_dir ? fwd_q : rev_q;
   // indexer auto enable of limit 2 while moving
   wire logic        use2    = sel_s || (ctrl_q[CTRL_INDEXER] && st_q == ST_MOVE);
   // limit 2 only when lower than both
   wire logic        l2_low  = (lim2_q < fwd_q) && (lim2_q < rev_q);
   wire logic [15:0] lim_c   = (use2 && l2_low) ? lim2_q : dir_lim;
   wire logic        hit     = run_ok && torque_req >= lim_c;
   logic             hit_q;
   always_ff @(posedge clk) begin
      if (reset) begin
         torque_out   <= '0;
         active_limit <= '0;
         hit_q        <= 1'b0;
      end else begin
         torque_out   <= !run_ok ? 16'h0000 : (hit ? lim_c : torque_req);
         active_limit <= lim_c;
         hit_q        <= hit;
      end
   end

   assign stat_out = ctrl_q[CTRL_TEST] ? stat_out_t'(force_q) : stat_out_t'({done_q, rough_q2, inp_q, hit_q});

   // axi4-lite write path
   logic        aw_ok_q, w_ok_q;
   logic [7:0]  awaddr_q;
   logic [31:0] wdata_q;
   assign s_axi_awready = !aw_ok_q && !s_axi_bvalid;
   assign s_axi_wready  = !w_ok_q && !s_axi_bvalid;
   assign s_axi_bresp   = 2'b00;
   wire logic wr_go = aw_ok_q && w_ok_q;
   wire logic [IRQ_W-1:0] ev = {start_edge && st_q == ST_IDLE && run_ok, done_c && !done_q, hit && !hit_q};
   wire logic [IRQ_W-1:0] clr = (wr_go && awaddr_q == OFS_IRQST) ? wdata_q[IRQ_W-1:0] : '0;
   always_ff @(posedge clk) begin
      if (reset) begin
         aw_ok_q      <= 1'b0;
         w_ok_q       <= 1'b0;
         s_axi_bvalid <= 1'b0;
         awaddr_q     <= '0;
         wdata_q      <= '0;
         ctrl_q       <= '0;
         inpos_q      <= RST_INPOS;
         rough_q      <= RST_ROUGH;
         fwd_q        <= RST_LIMIT;
         rev_q        <= RST_LIMIT;
         lim2_q       <= RST_LIMIT;
         irqmsk_q     <= '0;
         force_q      <= '0;
         irqst_q      <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_ok_q  <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_ok_q  <= 1'b1;
            wdata_q <= s_axi_wdata;
         end
         if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
         if (wr_go) begin
            aw_ok_q <= 1'b0; w_ok_q <= 1'b0; s_axi_bvalid <= 1'b1;
            if      (awaddr_q == OFS_CTRL)   ctrl_q   <= wdata_q[1:0];
            else if (awaddr_q == OFS_INPOS)  inpos_q  <= wdata_q[15:0];
            else if (awaddr_q == OFS_ROUGH)  rough_q  <= wdata_q[15:0];
            else if (awaddr_q == OFS_FWD)    fwd_q    <= wdata_q[15:0];
            else if (awaddr_q == OFS_REV)    rev_q    <= wdata_q[15:0];
            else if (awaddr_q == OFS_LIM2)   lim2_q   <= wdata_q[15:0];
            else if (awaddr_q == OFS_IRQMSK) irqmsk_q <= wdata_q[IRQ_W-1:0];
            else if (awaddr_q == OFS_FORCE)  force_q  <= wdata_q[3:0];
         end
         // set wins over clear
         irqst_q <= (irqst_q & ~clr) | ev;
      end
   end
   assign irq = |(irqst_q & irqmsk_q);

   // axi4-lite read path
   wire logic [31:0] rd_c =
      (s_axi_araddr == OFS_CTRL)   ? {30'h0, ctrl_q} :
      (s_axi_araddr == OFS_STATUS) ? {24'h0, st_q, ready_out, mpow_s, done_q, rough_q2, inp_q, hit_q} :
      (s_axi_araddr == OFS_INPOS)  ? {16'h0, inpos_q} :
      (s_axi_araddr == OFS_ROUGH)  ? {16'h0, rough_q} :
      (s_axi_araddr == OFS_FWD)    ? {16'h0, fwd_q} :
      (s_axi_araddr == OFS_REV)    ? {16'h0, rev_q} :
      (s_axi_araddr == OFS_LIM2)   ? {16'h0, lim2_q} :
      (s_axi_araddr == OFS_IRQST)  ? {29'h0, irqst_q} :
      (s_axi_araddr == OFS_IRQMSK) ? {29'h0, irqmsk_q} :
      (s_axi_araddr == OFS_FORCE)  ? {28'h0, force_q} : 32'h0000_0000;
   assign s_axi_arready = !s_axi_rvalid;
   assign s_axi_rresp   = 2'b00;
   always_ff @(posedge clk) begin
      if (reset) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_c;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // checks
   chk_no_start_unpow: assert property (@(posedge clk) disable iff (reset) !mpow_s |-> !start_edge)
      else $error("start accepted without main power");
   chk_edge_only: assert property (@(posedge clk) disable iff (reset) (st_q == ST_IDLE && !(tick && start_s && !start_prev_q)) |=> st_q != ST_DELAY)
      else $error("start on level");
   chk_start_lat: assert property (@(posedge clk) disable iff (reset) (st_q == ST_IDLE && start_edge) |-> ##[1:3] (motion_start || !run_ok))
      else $error("start latency too long");
   chk_busy_ignore: assert property (@(posedge clk) disable iff (reset) (st_q == ST_MOVE && run_ok) |=> st_q != ST_DELAY)
      else $error("start taken while moving");
   chk_done_servo: assert property (@(posedge clk) disable iff (reset) !run_ok |=> !done_q && !rough_q2 && !inp_q)
      else $error("status without servo on");
   chk_resume_all: assert property (@(posedge clk) disable iff (reset) resumed |=> done_q && rough_q2 && inp_q)
      else $error("resume status missing");
   chk_clamp: assert property (@(posedge clk) disable iff (reset) 1'b1 |=> torque_out <= $past(lim_c))
      else $error("torque above limit");
   chk_limit_flag: assert property (@(posedge clk) disable iff (reset) (run_ok && torque_req >= lim_c) |=> hit_q)
      else $error("limiting flag missing");
   chk_servo_off: assert property (@(posedge clk) disable iff (reset) !run_ok |=> st_q == ST_IDLE && torque_out == 16'h0000)
      else $error("operation not ended on servo off");
   chk_sel_lim2: assert property (@(posedge clk) disable iff (reset) (sel_s && l2_low) |=> active_limit == $past(lim2_q))
      else $error("limit 2 not applied on select");
   chk_idx_lim2: assert property (@(posedge clk) disable iff (reset) (ctrl_q[CTRL_INDEXER] && st_q == ST_MOVE && l2_low) |=> active_limit == $past(lim2_q))
      else $error("limit 2 not applied in indexer move");
endmodule : servo_start_and_torque_limit_logic

// ===== host_plc_model.sv
// host controller model driving the remote bits of the drive
`timescale 1ns/1ps
module host_plc_model
   import servo_pkg::*;
#(
   parameter int unsigned HOLD_CLKS = 24  // start on time in clocks
) (
   input  wire logic clk,        // clock
   input  wire logic ready_out,  // drive ready
   output host_in_t  host_in     // remote bits
);
   // all bits off at power-up
   initial host_in = '0;
   // set the level bits after an edge
   task automatic set_bits(input logic servo, input logic sel, input logic run);
      @(posedge clk);
      host_in.servo_on_bit            <= servo;
      host_in.torque_limit_select_bit <= sel;
      host_in.forced_stop_in          <= run;
   endtask : set_bits
   // one start pulse, optionally gated by ready
   task automatic press_start(input bit lock);
      int n;
      n = 0;
      while (lock && ready_out !== 1'b1 && n < 200) begin
         @(posedge clk);
         n++;
      end
      @(posedge clk);
      host_in.start_cmd_bit <= 1'b1;
      repeat (HOLD_CLKS) @(posedge clk);
      host_in.start_cmd_bit <= 1'b0;
      // keep start off long enough for the drive to sample the low level
      repeat (HOLD_CLKS) @(posedge clk);
   endtask : press_start
endmodule : host_plc_model

// ===== tb_top.sv
// testbench for the servo start and torque limit logic
`timescale 1ns/1ps
module tb_top
   import servo_pkg::*;
();
   localparam int unsigned CYC = 4;
   localparam int LAT = 3 * CYC + 4;
   localparam logic [2:0]  TSEL [5] = '{3'b010, 3'b000, 3'b001, 3'b110, 3'b100};
   localparam logic [15:0] TL2  [5] = '{16'h0050, 16'h0050, 16'h0050, 16'h0050, 16'h0300};
   localparam logic [15:0] TEXP [5] = '{16'h0100, 16'h0200, 16'h0100, 16'h0050, 16'h0200};
   localparam logic [7:0]  ROFS [6] = '{OFS_INPOS, OFS_ROUGH, OFS_FWD, OFS_REV, OFS_LIM2, 8'h3C};
   localparam logic [15:0] RVAL [6] = '{RST_INPOS, RST_ROUGH, RST_LIMIT, RST_LIMIT, RST_LIMIT, 16'h0000};
   logic clk = 1'b0, reset = 1'b1, main_power_ok = 1'b0, alarm_in = 1'b0;
   logic cmd_done = 1'b0, torque_ccw = 1'b0, regen = 1'b0;
   logic [15:0] cmd_remain = '0, droop = '0, torque_req = '0, torque_out, active_limit;
   logic motion_start, power_on, ready_out, irq;
   host_in_t host_in;
   stat_out_t stat_out;
   logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = '0;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   int error_cnt = 0, compares = 0, cyc = 0, starts = 0, last_st = 0;

   servo_start_and_torque_limit_logic #(.CYCLE_CLKS(CYC), .POS_W(16)) u_servo_start_and_torque_limit_logic (
      .clk, .reset, .host_in, .main_power_ok, .alarm_in, .cmd_remain, .droop, .cmd_done,
      .torque_req, .torque_ccw, .regen, .torque_out, .active_limit, .motion_start, .power_on,
      .ready_out, .stat_out, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);
   host_plc_model #(.HOLD_CLKS(6 * CYC)) u_host_plc_model (.clk, .ready_out, .host_in);

   // clock generator
   always #5 clk = ~clk;
   // cycle count, start pulse log and hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (motion_start === 1'b1) begin
         starts  <= starts + 1;
         last_st <= cyc;
      end
      if (cyc == 20000) begin
         error_cnt++;
         $display("unexpected at %0t: timeout", $time);
         complete_run();
      end
   end
   // counts and verdict
   task automatic complete_run();
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : complete_run
   // compare one value
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   // one register write, address and data offered together
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
      bit aw_ok, w_ok;
      aw_ok = 0;
      w_ok  = 0;
      @(posedge clk);
      s_axi_awaddr  <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= 4'hF;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge clk);
         if (!aw_ok && s_axi_awready === 1'b1) begin
            aw_ok = 1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_ok && s_axi_wready === 1'b1) begin
            w_ok = 1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge clk); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
   endtask : axi_write
   // one register read
   task automatic axi_read(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do @(posedge clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge clk); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      s_axi_rready <= 1'b0;
   endtask : axi_read

   // main sequence
   initial begin
      logic [31:0] rd;
      int s0, t0;
      bit seen;
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         axi_read(ROFS[i], rd);
         chk(rd, {16'h0000, RVAL[i]}, "reset value");
      end
      $display("test reset values done");
      u_host_plc_model.set_bits(1'b1, 1'b0, 1'b1);
      s0 = starts;
      u_host_plc_model.press_start(1'b0);
      repeat (LAT) @(posedge clk);
      chk(starts - s0, 0, "start without main power");
      main_power_ok <= 1'b1;
      repeat (6) @(posedge clk);
      s0 = starts;
      t0 = cyc;
      u_host_plc_model.press_start(1'b1);
      chk(starts - s0, 1, "one start per edge");
      chk(32'(last_st - t0 <= LAT), 1, "start latency");
      s0 = starts;
      u_host_plc_model.press_start(1'b1);
      chk(starts - s0, 0, "start while moving");
      $display("test start done");
      droop    <= 16'h0200;
      cmd_done <= 1'b1;
      repeat (8) @(posedge clk);
      chk(32'(stat_out[3:1]), 3'b010, "droop above range");
      droop <= 16'h0010;
      repeat (8) @(posedge clk);
      chk(32'(stat_out[3:1]), 3'b111, "inside range");
      cmd_done <= 1'b0;
      s0 = starts;
      u_host_plc_model.press_start(1'b1);
      chk(starts - s0, 1, "next start after done");
      u_host_plc_model.set_bits(1'b0, 1'b0, 1'b1);
      repeat (8) @(posedge clk);
      chk({power_on, stat_out[3:2]}, 0, "servo off");
      u_host_plc_model.set_bits(1'b1, 1'b0, 1'b1);
      seen = 0;
      repeat (16) begin
         @(posedge clk);
         if (stat_out[3:1] === 3'b111)
            seen = 1;
      end
      chk(seen, 1, "resume after stop");
      cmd_done <= 1'b1;
      $display("test status done");
      axi_write(OFS_FWD, 32'h0000_0100);
      axi_write(OFS_REV, 32'h0000_0200);
      torque_req <= 16'hFFFF;
      for (int i = 0; i < 5; i++) begin
         u_host_plc_model.set_bits(1'b1, TSEL[i][2], 1'b1);
         torque_ccw <= TSEL[i][1];
         regen      <= TSEL[i][0];
         axi_write(OFS_LIM2, {16'h0000, TL2[i]});
         repeat (6) @(posedge clk);
         chk(active_limit, TEXP[i], "limit select");
         chk({torque_out, stat_out[0]}, {TEXP[i], 1'b1}, "clamp");
      end
      torque_req <= 16'h0010;
      repeat (6) @(posedge clk);
      chk({torque_out, stat_out[0]}, {16'h0010, 1'b0}, "below limit");
      $display("test torque done");
      axi_write(OFS_IRQMSK, 32'h0000_0000);
      axi_read(OFS_IRQST, rd);
      chk(rd[0], 1'b1, "limiting event");
      chk(irq, 1'b0, "masked");
      axi_write(OFS_IRQMSK, 32'h0000_0001);
      repeat (2) @(posedge clk);
      chk(irq, 1'b1, "unmasked");
      axi_write(OFS_IRQST, 32'h0000_0007);
      axi_read(OFS_IRQST, rd);
      chk(rd, 0, "cleared");
      chk(irq, 1'b0, "irq low");
      $display("test interrupt done");
      axi_write(OFS_CTRL, 32'h0000_0002);
      for (int v = 5; v <= 10; v += 5) begin
         axi_write(OFS_FORCE, v);
         repeat (2) @(posedge clk);
         chk(32'(stat_out), v, "forced outputs");
      end
      axi_write(OFS_CTRL, 32'h0000_0000);
      $display("test forced output done");
      u_host_plc_model.set_bits(1'b1, 1'b0, 1'b1);
      axi_write(OFS_CTRL, 32'h0000_0001);
      axi_write(OFS_LIM2, 32'h0000_0050);
      torque_req <= 16'hFFFF;
      cmd_done   <= 1'b0;
      u_host_plc_model.press_start(1'b1);
      chk(active_limit, 16'h0050, "indexer limit 2 while moving");
      cmd_done <= 1'b1;
      repeat (6) @(posedge clk);
      chk(active_limit, 16'h0200, "indexer limit 2 off when idle");
      $display("test indexer done");
      complete_run();
   end
endmodule : tb_top
